// >>> hdl/adc_flow_control_config.sv
// Flow-control configuration slice of a converter sequencer.
// Assumes conversion engine and trigger logic on i_core_clk.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`include "adc_flow_params.svh"

module adc_flow_control_config (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire adc_flow_pkg::apb_req_t i_apb,
  output adc_flow_pkg::apb_rsp_t o_apb,
  input wire logic i_special_mode,
  input wire logic i_int_wr,
  input wire adc_flow_pkg::flow_bits_t i_int_flow,
  input wire logic i_list_active,
  input wire logic i_conv_busy,
  input wire logic i_conv_last,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_data,
  input wire logic [5:0] i_conv_index,
  input wire logic i_end_of_list,
  input wire logic i_abort_done,
  output logic o_launch,
  output logic o_conv_discard,
  output logic o_flow_mode,
  output adc_flow_pkg::flow_bits_t o_flow,
  output logic o_irq
);

  // ===================================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  // Async assert, two-flop release so no flop sees a ragged edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ===================================================================
  // Register state
  logic enable;
  logic special_access;
  logic [1:0] flow_access_select;
  logic store_on_abort;
  logic flow_mode_select;
  adc_flow_pkg::flow_bits_t flow_control_register;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [11:0] result;
  logic [5:0] result_info;
  adc_flow_pkg::flow_state_t state;
  logic launch;
  logic discard;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ===================================================================
  // APB decode
  wire logic acc_phase = i_apb.psel & i_apb.penable;
  wire logic bus_wr = acc_phase & i_apb.pwrite;
  wire logic sel_ctl0 = hit(i_apb.paddr, `AFC_OFS_CTL0);
  wire logic sel_ctl1 = hit(i_apb.paddr, `AFC_OFS_CTL1);
  wire logic sel_flow = hit(i_apb.paddr, `AFC_OFS_FLOW);
  wire logic sel_stat = hit(i_apb.paddr, `AFC_OFS_STAT);
  wire logic sel_mask = hit(i_apb.paddr, `AFC_OFS_MASK);
  wire logic sel_res = hit(i_apb.paddr, `AFC_OFS_RES);
  wire logic sel_info = hit(i_apb.paddr, `AFC_OFS_INFO);
  wire logic mapped = sel_ctl0 | sel_ctl1 | sel_flow | sel_stat |
    sel_mask | sel_res | sel_info;

  // Configuration lock while the converter runs
  wire logic cfg_wr_ok = ~enable | special_access;

  // ===================================================================
  // Flow-control requests, each path gated by its access bit
  wire logic bus_flow_wr = bus_wr & sel_flow &
    flow_access_select[1];
  wire logic int_flow_wr = i_int_wr &
    flow_access_select[0];
  wire adc_flow_pkg::flow_bits_t bus_req =
    bus_flow_wr ? i_apb.pwdata[3:0] : 4'h0;
  wire adc_flow_pkg::flow_bits_t int_req =
    int_flow_wr ? i_int_flow : 4'h0;
  // Software and trigger logic share the bits by OR
  wire adc_flow_pkg::flow_bits_t req = bus_req | int_req;

  wire logic abort_evt = req.sequence_abort_bit;
  wire logic restart_evt = req.restart_bit;
  wire logic cut_evt = (abort_evt | restart_evt) & i_conv_busy;

  // Lone restart while a list runs; last conversion spared if storing
  wire logic lone_restart = restart_evt & ~abort_evt &
    ~flow_control_register.sequence_abort_bit;
  wire logic restart_err = lone_restart & i_list_active &
    (store_on_abort ? ~i_conv_last : 1'b1);

  // Result capture: cut conversions store only with store-on-abort
  wire logic store_cut = cut_evt & store_on_abort;
  wire logic drop_cut = cut_evt & ~store_on_abort;
  wire logic store_now = store_cut | (i_conv_done & ~cut_evt);

  // ===================================================================
  // Next values of the flow register
  wire logic next_sequence_abort_bit = (flow_control_register.sequence_abort_bit &
    ~i_abort_done) | abort_evt | restart_err;
  wire logic next_load_ok_bit = (flow_control_register.load_ok_bit &
    ~restart_evt) | req.load_ok_bit;

  // Interrupt status: hardware set wins over write-one-clear
  wire logic [1:0] irq_set = {store_now, restart_err};
  wire logic [1:0] irq_clr = (bus_wr & sel_stat) ?
    i_apb.pwdata[1:0] : 2'h0;
  wire logic [1:0] next_status = (irq_status & ~irq_clr) | irq_set;

  // ===================================================================
  // Control registers 0 and 1
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      flow_access_select <= `AFC_RST_ACC;
      store_on_abort <= 1'b0;
      flow_mode_select <= 1'b0;
    end else if (bus_wr && sel_ctl0) begin
      enable <= i_apb.pwdata[`AFC_BIT_EN];
      if (cfg_wr_ok) begin
        flow_access_select <=
          i_apb.pwdata[`AFC_BIT_ACC_HI:`AFC_BIT_ACC_LO];
        store_on_abort <= i_apb.pwdata[`AFC_BIT_STORE];
        flow_mode_select <= i_apb.pwdata[`AFC_BIT_MODE];
      end
    end
  end

  // Special access lives only inside special mode
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      special_access <= 1'b0;
    end else if (!i_special_mode) begin
      special_access <= 1'b0;
    end else if (bus_wr && sel_ctl1) begin
      special_access <= i_apb.pwdata[`AFC_BIT_SPECIAL];
    end
  end

  // ===================================================================
  // Flow register: restart and trigger are one-cycle requests
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flow_control_register <= 4'h0;
    end else begin
      flow_control_register <= {next_sequence_abort_bit, req.restart_bit,
        req.trigger_bit, next_load_ok_bit};
    end
  end

  // ===================================================================
  // Interrupt status and mask
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `AFC_RST_IRQ;
      irq_mask <= `AFC_RST_IRQ;
    end else begin
      irq_status <= next_status;
      if (bus_wr && sel_mask) begin
        irq_mask <= i_apb.pwdata[1:0];
      end
    end
  end

  // ===================================================================
  // Result and intermediate result information
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 12'h000;
      result_info <= 6'h00;
      discard <= 1'b0;
    end else begin
      discard <= drop_cut;
      if (store_now) begin
        result <= i_conv_data;
        result_info <= i_conv_index;
      end
    end
  end

  // ===================================================================
  // Flow sequencer: mode decides what follows restart and end of list
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= adc_flow_pkg::st_idle;
      launch <= 1'b0;
    end else begin
      launch <= 1'b0;
      if (restart_evt) begin
        if (flow_mode_select) begin
          state <= adc_flow_pkg::st_wait_trigger_bit;
        end else begin
          state <= adc_flow_pkg::st_run;
          launch <= 1'b1;
        end
      end else begin
        unique case (state)
          adc_flow_pkg::st_idle: begin
          end
          adc_flow_pkg::st_wait_trigger_bit: begin
            if (req.trigger_bit) begin
              state <= adc_flow_pkg::st_run;
              launch <= 1'b1;
            end
          end
          adc_flow_pkg::st_run: begin
            if (i_end_of_list) begin
              state <= flow_mode_select ? adc_flow_pkg::st_wait_trigger_bit :
                adc_flow_pkg::st_idle;
            end
          end
          default: begin
            state <= adc_flow_pkg::st_idle;
          end
        endcase
      end
    end
  end

  // ===================================================================
  // Read mux; zero wait states, unmapped answers with pslverr
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_ctl0) begin
      rd_data[`AFC_BIT_EN] = enable;
      rd_data[`AFC_BIT_ACC_HI:`AFC_BIT_ACC_LO] = flow_access_select;
      rd_data[`AFC_BIT_STORE] = store_on_abort;
      rd_data[`AFC_BIT_MODE] = flow_mode_select;
    end
    if (sel_ctl1) rd_data[`AFC_BIT_SPECIAL] = special_access;
    if (sel_flow) rd_data[3:0] = flow_control_register;
    if (sel_stat) rd_data[1:0] = irq_status;
    if (sel_mask) rd_data[1:0] = irq_mask;
    if (sel_res) rd_data[11:0] = result;
    if (sel_info) rd_data[5:0] = result_info;
  end

  assign o_apb.prdata = rd_data;
  assign o_apb.pready = 1'b1;
  assign o_apb.pslverr = acc_phase & ~mapped;
  assign o_launch = launch;
  assign o_conv_discard = discard;
  assign o_flow_mode = flow_mode_select;
  assign o_flow = flow_control_register;
  assign o_irq = |(irq_status & irq_mask);

  // ===================================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  // Anything that may start a list one cycle later
  wire logic launch_cause = restart_evt | req.trigger_bit;

  sequence s_lone_restart;
    restart_evt && !abort_evt && i_list_active &&
      !flow_control_register.sequence_abort_bit;
  endsequence

  sequence s_trigger_bit_wait;
    state == adc_flow_pkg::st_wait_trigger_bit && !restart_evt;
  endsequence

  a_bus_path_gate: assert property (
    (bus_wr && sel_flow && !flow_access_select[1] && !int_flow_wr)
      |=> flow_control_register.load_ok_bit ==
        $past(flow_control_register.load_ok_bit))
    else $error("bus flow write passed a closed path");

  a_int_path_gate: assert property (
    (i_int_wr && i_int_flow.load_ok_bit && !flow_access_select[0] &&
      !bus_flow_wr && !flow_control_register.load_ok_bit)
      |=> !flow_control_register.load_ok_bit)
    else $error("internal flow write passed a closed path");

  a_cfg_lock: assert property (
    (bus_wr && sel_ctl0 && enable && !special_access)
      |=> $stable(flow_access_select) && $stable(store_on_abort) &&
        $stable(flow_mode_select))
    else $error("locked configuration changed");

  a_drop_result: assert property (
    (cut_evt && !store_on_abort)
      |=> o_conv_discard && $stable(result))
    else $error("cut conversion result not dropped");

  a_store_result: assert property (
    (cut_evt && store_on_abort)
      |=> result == $past(i_conv_data) &&
        result_info == $past(i_conv_index) &&
        irq_status[`AFC_BIT_DONE])
    else $error("cut conversion result not stored");

  a_err_no_store: assert property (
    (s_lone_restart and !store_on_abort)
      |=> irq_status[`AFC_BIT_ERR] &&
        flow_control_register.sequence_abort_bit)
    else $error("restart error missed without store");

  a_last_no_err: assert property (
    (s_lone_restart and (store_on_abort && i_conv_last &&
      !irq_status[`AFC_BIT_ERR]))
      |=> !irq_status[`AFC_BIT_ERR])
    else $error("restart error raised on last conversion");

  a_err_store: assert property (
    (s_lone_restart and (store_on_abort && !i_conv_last))
      |=> irq_status[`AFC_BIT_ERR] &&
        flow_control_register.sequence_abort_bit)
    else $error("restart error missed with store");

  a_mode_restart: assert property (
    (restart_evt && !flow_mode_select)
      |=> o_launch ##1 (!o_launch || $past(launch_cause)))
    else $error("restart mode did not launch");

  a_mode_trigger: assert property (
    (restart_evt && flow_mode_select)
      |=> !o_launch && state == adc_flow_pkg::st_wait_trigger_bit)
    else $error("trigger mode launched without trigger");

  a_trigger_bit_launch: assert property (
    (s_trigger_bit_wait ##0 req.trigger_bit) |=> o_launch)
    else $error("trigger did not launch");

endmodule : adc_flow_control_config

// >>> hdl/adc_flow_params.svh
// Constants of the converter flow-control configuration slice.
// Assumes an APB slave with byte addresses and 32-bit data.
//
// Behaviour
// - Access bits 11-10 gate flow writes: 00 none, 01 int, 10 bus, 11 both.
// - Store clear: abort or restart mid-conversion drops result, no done flag.
// - Store clear: lone restart before last conversion done: error, abort.
// - Store set: abort or restart mid-conversion stores result, flag and info.
// - Store set: lone restart during the last conversion raises no error.
// - Store set: lone restart while not in the last conversion sets error and abort.
// - Mode bit 8 after restart or end of list: 0 restart mode, 1 trigger mode.
// - Mode, store and access bits writable only if disabled or special access.
`ifndef ADC_FLOW_PARAMS_SVH
`define ADC_FLOW_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define AFC_OFS_CTL0 8'h00
`define AFC_OFS_CTL1 8'h04
`define AFC_OFS_FLOW 8'h08
`define AFC_OFS_STAT 8'h0C
`define AFC_OFS_MASK 8'h10
`define AFC_OFS_RES 8'h14
`define AFC_OFS_INFO 8'h18

// =====================================================================
// Field positions
`define AFC_BIT_EN 15
`define AFC_BIT_ACC_HI 11
`define AFC_BIT_ACC_LO 10
`define AFC_BIT_STORE 9
`define AFC_BIT_MODE 8
`define AFC_BIT_SPECIAL 5
`define AFC_BIT_ERR 0
`define AFC_BIT_DONE 1

// =====================================================================
// Reset values
`define AFC_RST_CTL0 16'h0000
`define AFC_RST_ACC 2'h0
`define AFC_RST_IRQ 2'h0

`endif

// >>> hdl/adc_flow_pkg.sv
// Types shared by the flow-control configuration slice.
// Assumes a single 10 MHz core clock domain.
package adc_flow_pkg;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Conversion flow bits, abort highest
  typedef struct packed {
    logic sequence_abort_bit;
    logic restart_bit;
    logic trigger_bit;
    logic load_ok_bit;
  } flow_bits_t;

  typedef enum logic [1:0] {
    st_idle,
    st_wait_trigger_bit,
    st_run
  } flow_state_t;

endpackage : adc_flow_pkg

// >>> bench/conv_engine_model.sv
// Behavioural conversion engine on the far side of the flow slice.
// Assumes one clock; i_go is a one-cycle pulse from the bench.
module conv_engine_model #(
  parameter int LEN = 6
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_go,
  input wire logic i_last,
  input wire logic i_stop,
  input wire logic [11:0] i_data,
  output logic o_busy,
  output logic o_last,
  output logic o_done,
  output logic [11:0] o_data,
  output logic [5:0] o_index
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // ==================================================================
  // Conversion timer, cut short by abort or restart from the flow bits
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_index <= 6'h00;
    end else begin
      o_done <= 1'b0;
      if (i_go && !o_busy) begin
        o_busy <= 1'b1;
        cnt <= LEN;
        o_index <= o_index + 6'h01;
      end else if (o_busy && i_stop) begin
        o_busy <= 1'b0;
      end else if (o_busy && cnt == 1) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else if (o_busy) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Stale data is inverted so nobody can rely on a released bus
  assign o_data = (o_busy || o_done) ? i_data : ~i_data;
  assign o_last = o_busy & i_last;
endmodule : conv_engine_model

// >>> bench/test_adc_flow_control_config.sv
// Self-checking bench of the flow-control configuration slice.
// Assumes APB at byte offsets and pready answering the access phase.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module test_adc_flow_control_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst_b = 0;
  adc_flow_pkg::apb_req_t req = '0;
  adc_flow_pkg::apb_rsp_t rsp;
  adc_flow_pkg::flow_bits_t int_flow = '0;
  adc_flow_pkg::flow_bits_t flow;
  logic int_wr = 0, spec = 0, list_act = 0, last = 0, go = 0;
  logic abort_done = 0, eol = 0, err;
  logic busy, clast, done, launch, discard, mode, irq;
  logic [11:0] cdata, din = 12'h000;
  logic [5:0] cidx;
  logic [31:0] rnd = 32'h0000_0028, rd;
  int failures = 0, checks_done = 0, discards = 0, launches = 0, convs = 0;
  // Table of flow cases: store, busy, last, cmd, err, stored
  logic [8:0] cases [6] = '{9'b0_1_0_0100_1_0, 9'b1_1_0_0100_1_1,
    9'b1_1_1_0100_0_1, 9'b0_0_0_0100_1_0, 9'b0_1_1_0100_1_0,
    9'b1_1_0_1000_0_1};
  adc_flow_control_config uut (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_apb(req), .o_apb(rsp), .i_special_mode(spec), .i_int_wr(int_wr),
    .i_int_flow(int_flow), .i_list_active(list_act), .i_conv_busy(busy),
    .i_conv_last(clast), .i_conv_done(done), .i_conv_data(cdata),
    .i_conv_index(cidx), .i_end_of_list(eol), .i_abort_done(abort_done),
    .o_launch(launch), .o_conv_discard(discard), .o_flow_mode(mode),
    .o_flow(flow), .o_irq(irq));
  conv_engine_model #(.LEN(6)) eng (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_go(go), .i_last(last), .i_stop(flow.restart_bit | flow[3]),
    .i_data(din), .o_busy(busy), .o_last(clast), .o_done(done),
    .o_data(cdata), .o_index(cidx));
  always #50 clk = ~clk;
  // Pulse counters, so a short pulse is never missed between checks
  always @(posedge clk) begin
    discards <= discards + int'(discard === 1'b1);
    launches <= launches + int'(launch === 1'b1);
  end
  function automatic logic [31:0] next_rnd(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    next_rnd = x ^ (x << 5);
  endfunction : next_rnd
  // ==================================================================
  // APB master: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk); // Let the write settle before callers look
  endtask : apb
  // Internal interface write of flow bits, one cycle wide
  task automatic int_req(input logic [3:0] f);
    @(posedge clk);
    int_wr <= 1'b1;
    int_flow <= f;
    @(posedge clk);
    int_wr <= 1'b0;
    @(posedge clk);
  endtask : int_req
  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000000;
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [3:0] c;
    logic m;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    // Every access select code against both paths
    for (int a = 0; a < 4; a++) begin
      c = 4'(a);
      apb(1'b1, 8'h00, {20'h0_0000, c[1:0], 10'h000});
      apb(1'b1, 8'h08, 32'h0000_0001);
      `CHK(flow.load_ok_bit, c[1])
      int_req(4'b0001);
      `CHK(flow.load_ok_bit, c[1] | c[0])
      apb(1'b1, 8'h08, 32'h0000_0004);
      int_req(4'b0100);
      repeat (3) @(posedge clk);
    end
    // Mode select and its write lock
    for (int i = 0; i < 4; i++) begin
      rnd = next_rnd(rnd);
      m = rnd[0];
      apb(1'b1, 8'h00, {23'h00_0003, m, 8'h00} << 0 | 32'h0000_0c00);
      `CHK(mode, m)
      apb(1'b1, 8'h00, {16'h0000, 7'h58, m, 8'h00});
      apb(1'b1, 8'h00, {16'h0000, 7'h58, ~m, 8'h00});
      `CHK(mode, m)
      spec <= 1'b1;
      apb(1'b1, 8'h04, 32'h0000_0020);
      apb(1'b1, 8'h00, {16'h0000, 7'h58, ~m, 8'h00});
      `CHK(mode, ~m)
      spec <= 1'b0;
      apb(1'b1, 8'h00, 32'h0000_0c00);
      apb(1'b1, 8'h00, 32'h0000_0c00);
    end
    // Launch after restart in restart mode, after trigger in trigger mode
    for (int i = 0; i < 2; i++) begin
      m = i[0];
      apb(1'b1, 8'h00, {16'h0000, 7'h06, m, 8'h00});
      c = 4'(launches);
      int_req(4'b0100);
      repeat (3) @(posedge clk);
      `CHK(4'(launches) - c, {3'b000, ~m})
      if (m) begin
        int_req(4'b0010);
        repeat (3) @(posedge clk);
        `CHK(4'(launches) - c, 4'h1)
      end
      eol <= 1'b1;
      @(posedge clk);
      eol <= 1'b0;
    end
    // Abort and restart against store-on-abort, busy and last
    for (int i = 0; i < 6; i++) begin
      rnd = next_rnd(rnd);
      apb(1'b1, 8'h00, {22'h00_0003, cases[i][8], 9'h000});
      apb(1'b1, 8'h10, {31'h0000_0000, i[0]});
      list_act <= 1'b1;
      last <= cases[i][6];
      din <= rnd[11:0];
      go <= cases[i][7];
      convs += int'(cases[i][7]);
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      c = 4'(discards);
      int_req(cases[i][5:2]);
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      `CHK(rd[0], cases[i][1])
      `CHK(rd[1], cases[i][0])
      `CHK(4'(discards) - c, {3'b000, ~cases[i][0] & cases[i][7]})
      `CHK(irq, rd[0] & i[0])
      if (cases[i][1]) `CHK(flow.sequence_abort_bit, 1'b1)
      if (cases[i][0]) begin
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK(rd[11:0], rnd[11:0])
        apb(1'b0, 8'h18, 32'h0000_0000);
        `CHK(rd[5:0], 6'(convs))
      end
      abort_done <= 1'b1;
      @(posedge clk);
      abort_done <= 1'b0;
      list_act <= 1'b0;
      apb(1'b1, 8'h0c, 32'h0000_0003);
      `CHK(irq, 1'b0)
      repeat (8) @(posedge clk);
    end
    tally_and_finish();
  end
endmodule : test_adc_flow_control_config
